// >>> logic/spi_error_irq_dma_support.sv
// serial port core with error flags, interrupt pulses and dma triggers
// assumes axi4-lite master on aclk; serial pins are asynchronous
// Function
// RULE1: collision write flags, transfer continues, byte dropped
// RULE2: collision detected as master and slave
// RULE3: dma slave tasm 0: collision pulses error
// RULE4: slave unread byte overwritten sets overrun
// RULE5: overrun pulses error only dma tasm 1
// RULE6: four interrupts, scheme chosen by mode bit
// RULE7: compat: fault and combined error pulses only
// RULE8: dma: mode fault rise pulses fault irq
// RULE9: dma: rx and tx done set together; a slave with phase 0 sets tx done later, at deselect
// RULE10: rx done rise pulses; read or w1c clears
// RULE11: tx done rise pulses; write or w1c clears
// RULE12: each interrupt individually maskable
// RULE13: software sets dma mode, two channels
// RULE14: lower channel serves receive trigger
// RULE15: software writes first byte to start
// RULE16: read serviced first clears rx done
// RULE17: master data write clears tx, starts transfer
// RULE18: count decrements, end pulse at zero
// RULE19: dma overrun clears only by writing one
// RULE20: disabled: writes ignored, reads return zero
// RULE21: master auto-shift read clears, restarts transfer
// RULE22: interrupts are one-cycle rising pulses
module spi_error_irq_dma_support (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             mode_fault_irq,
  output logic             error_irq,
  output logic             receive_complete_irq,
  output logic             transmit_complete_irq,
  output logic             dma_end_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]  s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
  logic [3:0]  ctrl_q, ctrl_d;
  logic        tmse_q, tmse_d;
  logic [4:0]  flag_q, flag_d, prev_q, prev_d;
  logic [4:0]  mask_q, mask_d;
  logic [15:0] cnt_q, cnt_d;
  logic [7:0]  shift_q, shift_d;
  logic        unread_q, unread_d;
  spi_pkg::xfer_e st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [7:0]  div_q, div_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [4:0]  waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        awr_d, wr_d, bv_d, arr_d, rv_d;
  logic [1:0]  bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic        sck_d, sck_oe_d, mo_d, mo_oe_d, mi_d, mi_oe_d;
  logic [4:0]  irq_d;
  logic        end_d;
  // flag vector index: 0 wcol 1 sovf 2 modf 3 rx done 4 tx done
  logic        en, mstr, tasm, clock_phase_select, busy, sck_rise, sck_fall, ss_low, ss_rise;
  logic        wr_go, rd_go, wr_data, rd_data, done, mdone;
  logic [4:0]  set, clr, rise;

  assign en   = ctrl_q[spi_pkg::CTRL_EN];
  assign mstr = ctrl_q[spi_pkg::CTRL_MSTR];
  assign tasm = ctrl_q[spi_pkg::CTRL_TASM];
  assign clock_phase_select = ctrl_q[spi_pkg::CTRL_CLOCK_PHASE_SELECT];
  assign busy = (st_q == spi_pkg::S_RUN);
  // input sync order: 0 sclk 1 mosi 2 miso 3 ss_n
  assign sck_rise = s2_q[0] & ~s3_q[0];
  assign sck_fall = ~s2_q[0] & s3_q[0];
  assign ss_low   = ~s2_q[3];
  assign ss_rise  = s2_q[3] & ~s3_q[3];
  assign wr_go    = aw_got_q & w_got_q;
  assign rd_go    = s_axi_arvalid & s_axi_arready;
  assign wr_data  = wr_go & (waddr_q == spi_pkg::DATA_OFS) & wstrb_q[0];
  assign rd_data  = rd_go & (s_axi_araddr == spi_pkg::DATA_OFS);
  assign rise     = flag_q & ~prev_q;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s1_d = {ss_n_in, miso_in, mosi_in, sclk_in};
    s2_d = s1_q;
    s3_d = s2_q;
    ctrl_d = ctrl_q;
    tmse_d = tmse_q;
    mask_d = mask_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    unread_d = unread_q;
    st_d = st_q;
    bit_d = bit_q;
    div_d = div_q;
    sck_d = sclk_out;
    mo_d = mosi_out;
    mi_d = miso_out;
    set = 5'h00;
    clr = 5'h00;
    done = 1'b0;
    mdone = 1'b0;
    end_d = 1'b0;
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bv_d = s_axi_bvalid & ~s_axi_bready;
    bresp_d = s_axi_bresp;
    rv_d = s_axi_rvalid & ~s_axi_rready;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    // ---- serial engine
    if (st_q == spi_pkg::S_RUN && mstr) begin
      div_d = div_q + 8'h01;
      if (div_q == spi_pkg::HALF_CYC - 8'h01) begin
        div_d = 8'h00;
        sck_d = ~sclk_out;
        if (!sclk_out) begin
          shift_d = {shift_q[6:0], s2_q[2]};
          bit_d = bit_q + 4'h1;
        end else if (bit_q == spi_pkg::BITS) begin
          done = 1'b1;
          mdone = 1'b1;
        end else begin
          mo_d = shift_q[7];
        end
      end
    end else if (!mstr && en && ss_low) begin
      if (sck_rise) begin
        st_d = spi_pkg::S_RUN;
        shift_d = {shift_q[6:0], s2_q[1]};
        bit_d = bit_q + 4'h1;
        if (bit_q == spi_pkg::BITS - 4'h1) begin
          done = 1'b1;
        end
      end else if (sck_fall) begin
        mi_d = shift_q[7];
      end
    end
    if (done) begin
      st_d = spi_pkg::S_IDLE;
      bit_d = 4'h0;
      sck_d = 1'b0;
      unread_d = 1'b1;
      set[3] = tmse_q;
      set[4] = tmse_q & (mstr | clock_phase_select); // [RULE9]
      if (!mstr && unread_q) begin
        set[1] = 1'b1; // [RULE4]
      end
    end
    // slave with phase 0 finishes its transmit side at deselect
    if (!mstr && !clock_phase_select && ss_rise && tmse_q && flag_q[3]) begin
      set[4] = 1'b1; // [RULE9]
    end
    if (!mstr && !ss_low && !done) begin
      st_d = spi_pkg::S_IDLE;
      bit_d = 4'h0;
    end
    // ---- mode fault: another master selected us
    if (mstr && en && ss_low) begin
      set[2] = 1'b1;
      ctrl_d[spi_pkg::CTRL_EN] = 1'b0;
      ctrl_d[spi_pkg::CTRL_MSTR] = 1'b0;
      st_d = spi_pkg::S_IDLE;
      bit_d = 4'h0;
      sck_d = 1'b0;
    end
    // ---- axi write channel
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = spi_pkg::RESP_OKAY;
      if (waddr_q == spi_pkg::CTRL_OFS) begin
        // control is locked while a mode fault is pending
        if (wstrb_q[0] && !flag_q[2]) begin
          ctrl_d = wdata_q[3:0];
        end
      end else if (waddr_q == spi_pkg::STAT_OFS) begin
        if (wstrb_q[0]) begin
          tmse_d = wdata_q[spi_pkg::ST_TMSE];
          clr = {wdata_q[spi_pkg::ST_TXD], wdata_q[spi_pkg::ST_RXD],
                 wdata_q[spi_pkg::ST_MODF], wdata_q[spi_pkg::ST_SOVF],
                 wdata_q[spi_pkg::ST_WCOL]}; // [RULE19]
          if (!wdata_q[spi_pkg::ST_TMSE]) begin
            clr[4:3] = 2'h3;
          end
        end
      end else if (waddr_q == spi_pkg::DATA_OFS) begin
        if (wstrb_q[0] && en) begin // [RULE20]
          if (busy) begin
            set[0] = 1'b1; // [RULE1] [RULE2]
          end else begin
            shift_d = wdata_q[7:0];
            clr[4] = 1'b1; // [RULE11]
            if (mstr) begin
              st_d = spi_pkg::S_RUN; // [RULE17]
              div_d = 8'h00;
              sck_d = 1'b0;
              mo_d = wdata_q[7];
            end else begin
              mi_d = wdata_q[7];
            end
          end
        end
      end else if (waddr_q == spi_pkg::MASK_OFS) begin
        if (wstrb_q[0]) begin
          mask_d = wdata_q[4:0];
        end
      end else if (waddr_q == spi_pkg::CNT_OFS) begin
        if (wstrb_q[0]) begin
          cnt_d[7:0] = wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          cnt_d[15:8] = wdata_q[15:8];
        end
      end else begin
        bresp_d = spi_pkg::RESP_SLVERR;
      end
    end
    // ---- axi read channel
    if (rd_go) begin
      rv_d = 1'b1;
      rresp_d = spi_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == spi_pkg::CTRL_OFS) begin
        rdata_d[3:0] = ctrl_q;
      end else if (s_axi_araddr == spi_pkg::STAT_OFS) begin
        rdata_d[6:0] = {busy, flag_q, tmse_q};
      end else if (s_axi_araddr == spi_pkg::DATA_OFS) begin
        if (en) begin
          rdata_d[7:0] = shift_q; // [RULE20]
          unread_d = 1'b0;
          clr[3] = 1'b1; // [RULE10] [RULE16]
          if (tmse_q && mstr && tasm && !busy) begin
            shift_d = 8'h00; // [RULE21]
            st_d = spi_pkg::S_RUN;
            div_d = 8'h00;
            sck_d = 1'b0;
            mo_d = 1'b0;
          end
        end
      end else if (s_axi_araddr == spi_pkg::MASK_OFS) begin
        rdata_d[4:0] = mask_q;
      end else if (s_axi_araddr == spi_pkg::CNT_OFS) begin
        rdata_d[15:0] = cnt_q;
      end else begin
        rresp_d = spi_pkg::RESP_SLVERR;
      end
    end
    // ---- dma block count: one step per byte moved
    if (tmse_q && cnt_q != 16'h0000 &&
        (mask_q[spi_pkg::MK_RX] ? rd_data && en : wr_data && en && !busy)) begin
      cnt_d = cnt_q - 16'h0001; // [RULE18]
      end_d = (cnt_q == 16'h0001) & mask_q[spi_pkg::MK_END];
    end
    // set wins over any clear in the same cycle
    flag_d = (flag_q & ~clr) | set;
    prev_d = flag_q;
    // ---- interrupt pulses on flag rising edges, gated by mask
    irq_d[0] = rise[2]; // [RULE8]
    if (tmse_q) begin
      irq_d[1] = ~mstr & ((~tasm & rise[0]) | (tasm & rise[1])); // [RULE3] [RULE5]
      irq_d[2] = rise[3]; // [RULE10]
      irq_d[3] = rise[4]; // [RULE11]
    end else begin
      irq_d[1] = (rise[0] | rise[1]) & ~(flag_q[0] & prev_q[1]) // [RULE7]
                 & ~(flag_q[1] & prev_q[0]);
      irq_d[2] = 1'b0;
      irq_d[3] = 1'b0;
    end
    irq_d[4] = 1'b0;
    irq_d = irq_d & mask_q; // [RULE6] [RULE12] [RULE22]
    // ---- pin drivers: outputs released while disabled
    sck_oe_d = en & ctrl_d[spi_pkg::CTRL_MSTR];
    mo_oe_d  = sck_oe_d;
    mi_oe_d  = en & ~ctrl_d[spi_pkg::CTRL_MSTR] & ss_low;
    awr_d = ~aw_got_d & ~bv_d;
    wr_d  = ~w_got_d & ~bv_d;
    arr_d = ~rv_d;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // idle pin levels (select high, clock low) so no false edge follows reset
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 4'h8;
      ctrl_q <= spi_pkg::CTRL_RST;
      tmse_q <= 1'b0;
      flag_q <= 5'h00;
      prev_q <= 5'h00;
      mask_q <= spi_pkg::MASK_RST;
      cnt_q <= spi_pkg::CNT_RST;
      shift_q <= spi_pkg::DATA_RST;
      unread_q <= 1'b0;
      st_q <= spi_pkg::S_IDLE;
      bit_q <= 4'h0;
      div_q <= 8'h00;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spi_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= spi_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      sclk_out <= 1'b0;
      sclk_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      {dma_end_irq, transmit_complete_irq, receive_complete_irq,
       error_irq, mode_fault_irq} <= 5'h00;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      ctrl_q <= ctrl_d;
      tmse_q <= tmse_d;
      flag_q <= flag_d;
      prev_q <= prev_d;
      mask_q <= mask_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      unread_q <= unread_d;
      st_q <= st_d;
      bit_q <= bit_d;
      div_q <= div_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awr_d;
      s_axi_wready <= wr_d;
      s_axi_bvalid <= bv_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arr_d;
      s_axi_rvalid <= rv_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
      sclk_out <= sck_d;
      sclk_oe <= sck_oe_d;
      mosi_out <= mo_d;
      mosi_oe <= mo_oe_d;
      miso_out <= mi_d;
      miso_oe <= mi_oe_d;
      {transmit_complete_irq, receive_complete_irq, error_irq,
       mode_fault_irq} <= irq_d[3:0];
      dma_end_irq <= end_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  coll_flagged_a: assert property (wr_data && en && busy |=> flag_q[0] // [RULE1]
    && (busy || $past(done) || $past(ss_rise) || flag_q[2]))
    else $error("collision write not flagged");
  slave_coll_a: assert property (wr_data && en && busy && !mstr |=> flag_q[0]) // [RULE2]
    else $error("slave collision missed");
  err_coll_a: assert property ($rose(flag_q[0]) && !prev_q[0] && tmse_q && !mstr // [RULE3]
    && !tasm && mask_q[1] |=> error_irq) else $error("collision error pulse missing");
  ovr_set_a: assert property (done && !mstr && unread_q |=> flag_q[1]) // [RULE4]
    else $error("overrun not set");
  err_ovr_gate_a: assert property (error_irq && $past(tmse_q) && $past(tasm) // [RULE5]
    |-> $past(rise[1])) else $error("error pulse without overrun");
  compat_quiet_a: assert property (!tmse_q |=> !receive_complete_irq // [RULE7]
    && !transmit_complete_irq) else $error("completion pulse in compat mode");
  fault_pulse_a: assert property (rise[2] && mask_q[0] |=> mode_fault_irq) // [RULE8]
    else $error("mode fault pulse missing");
  both_done_a: assert property (mdone && tmse_q |=> flag_q[3] && flag_q[4]) // [RULE9]
    else $error("done flags not set together");
  rx_read_clr_a: assert property (rd_data && en && !set[3] |=> !flag_q[3]) // [RULE10]
    else $error("receive done not cleared");
  off_read_zero_a: assert property (rd_data && !en |=> s_axi_rdata == 32'h0) // [RULE20]
    else $error("disabled read not zero");
  irq_pulse_a: assert property (error_irq || receive_complete_irq |=> // [RULE22]
    !(error_irq && $past(error_irq)) && !(receive_complete_irq && $past(receive_complete_irq)))
    else $error("interrupt longer than one cycle");
  cnt_end_a: assert property (cnt_q == 16'h0001 && cnt_d == 16'h0000 // [RULE18]
    && mask_q[4] |=> dma_end_irq) else $error("block end pulse missing");
endmodule

// >>> logic/spi_pkg.sv
// constants for the serial port error, interrupt and dma support block
// assumes a 10 MHz system clock and an axi4-lite register master
package spi_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] STAT_OFS = 5'h04;
  localparam logic [4:0] DATA_OFS = 5'h08;
  localparam logic [4:0] MASK_OFS = 5'h0c;
  localparam logic [4:0] CNT_OFS  = 5'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MSTR = 1;
  localparam int CTRL_TASM = 2;
  localparam int CTRL_CLOCK_PHASE_SELECT = 3;
  localparam int ST_TMSE   = 0;
  localparam int ST_WCOL   = 1;
  localparam int ST_SOVF   = 2;
  localparam int ST_MODF   = 3;
  localparam int ST_RXD    = 4;
  localparam int ST_TXD    = 5;
  localparam int ST_BUSY   = 6;
  localparam int MK_MF     = 0;
  localparam int MK_ERR    = 1;
  localparam int MK_RX     = 2;
  localparam int MK_TX     = 3;
  localparam int MK_END    = 4;
  // ----------------------------------------------------------------
  // reset values, responses, timing
  // ----------------------------------------------------------------
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [4:0]  MASK_RST    = 5'h1f;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          CLK_NS      = 100;
  localparam int          HALF_NS     = 400;
  localparam logic [7:0]  HALF_CYC    = 8'((HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  BITS        = 4'h8;
  typedef enum logic {S_IDLE, S_RUN} xfer_e;
endpackage

// >>> test/remote_serial.sv
// far-side serial partner: an echoing slave, or a master that sends bytes
// assumes the bench resolves each shared pin from the core's output enables
module remote_serial (
  input  wire logic sclk_w,
  input  wire logic mosi_w,
  output logic      sclk_o,
  output logic      mosi_o,
  output logic      miso_o,
  output logic      ss_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] shreg;
  logic       smp;
  // --------------------------------------------------------------
  // slave role: sample on rising, shift on falling, echo last byte
  // --------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
    shreg  = 8'h00;
    smp    = 1'b0;
  end
  always @(posedge sclk_w) smp = mosi_w;
  always @(negedge sclk_w) shreg = {shreg[6:0], smp};
  assign miso_o = shreg[7];
  task automatic load(input logic [7:0] b);
    shreg = b;
  endtask
  // --------------------------------------------------------------
  // master role: link clock only moves inside a frame
  // --------------------------------------------------------------
  task automatic send(input logic [7:0] b);
    ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      #400 sclk_o = 1'b1;
      #400 sclk_o = 1'b0;
    end
    #400 ss_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line must not keep the last bit
    #400; // lets the deselect pass the synchroniser before the caller looks
  endtask
  task automatic fault;
    ss_n_o = 1'b0;
    #1000 ss_n_o = 1'b1;
  endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the serial error, interrupt and dma block
// assumes remote_serial on the far side and a 10 MHz aclk
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] CT = spi_pkg::CTRL_OFS;
  localparam logic [4:0] ST = spi_pkg::STAT_OFS;
  localparam logic [4:0] DT = spi_pkg::DATA_OFS;
  localparam logic [4:0] MK = spi_pkg::MASK_OFS;
  localparam logic [4:0] CN = spi_pkg::CNT_OFS;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [4:0]  awaddr, araddr, irq, irq_p;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rrsp, brsp;
  logic        sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        sclk_o, mosi_o, miso_o, ss_n_o, sclk_w, mosi_w, miso_w;
  int          cnt [5];
  int          n_mismatch, n_compared;
  spi_error_irq_dma_support spi_error_irq_dma_support_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_n_in(ss_n_o), .mode_fault_irq(irq[0]), .error_irq(irq[1]),
    .receive_complete_irq(irq[2]), .transmit_complete_irq(irq[3]),
    .dma_end_irq(irq[4]));
  remote_serial remote_serial_i (.sclk_w(sclk_w), .mosi_w(mosi_w), .sclk_o(sclk_o),
    .mosi_o(mosi_o), .miso_o(miso_o), .ss_n_o(ss_n_o));
  assign sclk_w = sclk_oe ? sclk_out : sclk_o;
  assign mosi_w = mosi_oe ? mosi_out : mosi_o;
  assign miso_w = miso_oe ? miso_out : miso_o;
  always #50 aclk = ~aclk;
  // --------------------------------------------------------------
  // interrupt pulse counters, sampled mid-cycle
  // --------------------------------------------------------------
  always @(negedge aclk) begin
    for (int i = 0; i < 5; i++) if (irq[i] === 1'b1) cnt[i]++;
    if (aresetn === 1'b1 && (irq & irq_p) !== 5'h00) fail("irq held");
    irq_p = irq;
  end
  // --------------------------------------------------------------
  // reporting and bus tasks
  // --------------------------------------------------------------
  task automatic fail(input string m);
    n_mismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) fail($sformatf("got %h expected %h", g, e));
  endtask
  task automatic tick(inout int n);
    @(negedge aclk);
    n++;
    if (n > 200) begin
      fail("wait timed out");
      end_sim();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit ta, tw, ka, kw;
    int n;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid} <= 2'h3;
    {ta, tw, n} = '0;
    while (!(ta && tw)) begin
      tick(n);
      ka = !ta && awready === 1'b1;
      kw = !tw && wready === 1'b1;
      @(posedge aclk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      ta = ta || ka;
      tw = tw || kw;
    end
    bready <= 1'b1;
    do tick(n); while (bvalid !== 1'b1);
    brsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    n = 0;
    do tick(n); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    {rdat, rrsp} = {rdata, rresp};
    @(posedge aclk);
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  task automatic ci(input int i, input int e);
    chk(32'(cnt[i]), 32'(e));
  endtask
  task automatic cz;
    for (int i = 0; i < 5; i++) cnt[i] = 0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      rd(ST);
      tick(n);
    end while (rdat[6] !== 1'b0);
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rc(CT, 32'h0);
    rc(ST, 32'h0);
    rc(MK, 32'h1f);
    rc(CN, 32'h0);
    rd(5'h13);
    chk(32'(rrsp), 32'(spi_pkg::RESP_SLVERR));
    wr(5'h16, 32'h1);
    chk(32'(brsp), 32'(spi_pkg::RESP_SLVERR));
    wr(DT, 32'h5a);
    wr(CT, 32'h1);
    rc(DT, 32'h0);
    wstrb <= 4'h2;
    wr(CN, 32'h1234);
    wstrb <= 4'hf;
    rc(CN, 32'h1200);
  endtask
  task automatic t_master;
    wr(ST, 32'h1);
    wr(CT, 32'h3);
    remote_serial_i.load(8'h3c);
    cz();
    wr(DT, 32'ha5);
    wr(DT, 32'h66);
    idle();
    chk(32'(remote_serial_i.shreg), 32'ha5);
    rc(ST, 32'h33);
    ci(1, 0);
    ci(2, 1);
    ci(3, 1);
    rc(DT, 32'h3c);
    rc(ST, 32'h23);
    wr(ST, 32'h3);
    wr(ST, 32'h21);
    rc(ST, 32'h1);
  endtask
  task automatic t_auto;
    wr(MK, 32'h1b);
    wr(CN, 32'h1);
    wr(CT, 32'h7);
    remote_serial_i.load(8'h99);
    cz();
    wr(DT, 32'h5a);
    idle();
    rc(ST, 32'h31);
    rc(CN, 32'h0);
    ci(4, 1);
    ci(2, 0);
    ci(3, 1);
    rc(DT, 32'h99);
    rc(ST, 32'h61);
    idle();
    chk(32'(remote_serial_i.shreg), 32'h0);
    wr(CT, 32'h3);
    rc(DT, 32'h5a);
    rc(ST, 32'h21);
    wr(DT, 32'h18);
    rc(ST, 32'h41);
    idle();
    rc(DT, 32'h0);
  endtask
  task automatic t_slave;
    wr(MK, 32'h1f);
    wr(ST, 32'h3f);
    wr(CT, 32'h1);
    cz();
    fork
      remote_serial_i.send(8'h81);
      begin
        repeat (30) @(posedge aclk);
        wr(DT, 32'h66);
      end
    join
    rc(ST, 32'h33);
    ci(1, 1);
    remote_serial_i.send(8'h24);
    rc(ST, 32'h37);
    ci(1, 1);
    rc(DT, 32'h24);
    wr(ST, 32'h1);
    rc(ST, 32'h27);
    wr(ST, 32'h5);
    rc(ST, 32'h23);
    wr(CT, 32'h5);
    remote_serial_i.send(8'h42);
    remote_serial_i.send(8'h18);
    ci(1, 2);
    wr(CT, 32'h0);
    rc(DT, 32'h0);
  endtask
  task automatic t_fault_compat;
    wr(ST, 32'h3f);
    wr(CT, 32'h3);
    cz();
    remote_serial_i.fault();
    rc(CT, 32'h0);
    rc(ST, 32'h9);
    ci(0, 1);
    wr(ST, 32'h9);
    wr(ST, 32'h0);
    wr(CT, 32'h3);
    cz();
    wr(DT, 32'h99);
    wr(DT, 32'h66);
    idle();
    ci(1, 1);
    ci(2, 0);
    ci(3, 0);
  endtask
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, irq_p} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_master();
    t_auto();
    t_slave();
    t_fault_compat();
    end_sim();
  end
endmodule
